// ---- core/hbc_defines.svh ----
`ifndef HBC_DEFINES_SVH
`define HBC_DEFINES_SVH
// How it works
// - Floating mode pin selects independent half-bridge control.
// - Half-bridge mode: each output follows only its own input, low or high side.
// - Mode low with both inputs low: outputs off, autosleep entry.
// - Split supply: logic supply gone means lockout sleep, outputs off.
// - Lockout turns off every FET and clears the overcurrent deglitch, disable and retry state.
// - Split supply: lockout follows only the logic supply monitor.
// - Single supply: lockout follows the motor supply monitor.
// - Lockout ends once the monitored supply is good again.
// - Overcurrent longer than the deglitch time disables FETs; shorter is ignored.
// - After the retry interval FETs follow the inputs again; a lasting fault keeps restarting the timer.
// - Half-bridge mode: overcurrent disables only the affected half-bridge.
// - One shared retry timer; a second fault restarts it and holds both off.
// - Over temperature disables all FETs until the flag drops.
// - Idle inputs in PWM mode: outputs off at once, sleep after the sleep delay.
// - Direction/enable mode, enable low: brake for the sleep delay, then sleep.
// - Leaving every sleep-entry input state returns the device to active.
// - Input autosleep on both variants; supply sleep on both, from the monitored supply.
// - Mode pin: low PWM, high direction/enable, floating half-bridge; never latched.
// - PWM: 00 coast, 10 forward, 01 reverse, 11 brake.
// - Direction/enable: enable low brakes, high drives by direction.
// - Dead time inserted between high and low side of each half-bridge.
`define HBC_CLK_MHZ     125
`define HBC_SLEEP_US    1000
`define HBC_WAKE_US     250
`define HBC_RETRY_US    1000
`define HBC_OCP_NS      1000
`define HBC_DEAD_NS     100
`define HBC_SLEEP_CYC   (`HBC_SLEEP_US * `HBC_CLK_MHZ)
`define HBC_WAKE_CYC    (`HBC_WAKE_US * `HBC_CLK_MHZ)
`define HBC_RETRY_CYC   (`HBC_RETRY_US * `HBC_CLK_MHZ)
`define HBC_OCP_CYC     ((`HBC_OCP_NS * `HBC_CLK_MHZ + 999) / 1000)
`define HBC_DEAD_CYC    ((`HBC_DEAD_NS * `HBC_CLK_MHZ + 999) / 1000)
`define HBC_CNT_W       32
`define HBC_DEAD_W      16
`define HBC_REG_CTRL    8'h00
`define HBC_REG_STATUS  8'h04
`define HBC_REG_FAULT   8'h08
`define HBC_CTRL_RST    8'h01
`define HBC_CTRL_SPLIT  0
`define HBC_FLT_UNDERVOLTAGE_LOCKOUT    0
`define HBC_FLT_TSD     1
`define HBC_FLT_OCP_A   2
`define HBC_FLT_OCP_B   3
`endif

// ---- core/hbc_pkg.sv ----
package hbc_pkg;
    // Decoded tri-level mode pin
    typedef enum logic [1:0] {MODE_LOW, MODE_HIGH, MODE_FLOAT} hbc_mode_t;
    // Requested state of one half-bridge
    typedef enum logic [1:0] {DRV_OFF, DRV_LOW, DRV_HIGH} hbc_drv_t;
    // Controller pins
    typedef struct packed {
        logic      direction_or_channel_a_pin;
        logic      enable_or_channel_b_pin;
        hbc_mode_t mode;
    } hbc_pins_t;
    // Analog monitor flags
    typedef struct packed {
        logic       logic_supply_ok;
        logic       motor_supply_ok;
        logic       over_temp;
        logic [1:0] over_current;
    } hbc_sense_t;
    // Gate drive of one half-bridge
    typedef struct packed {
        logic high_on;
        logic low_on;
    } hbc_gate_t;
endpackage : hbc_pkg

// ---- core/hbc_gate.sv ----
`timescale 1ns/1ps
`include "hbc_defines.svh"
module hbc_gate
    import hbc_pkg::*;
#(
    parameter int unsigned DEAD_CYC = `HBC_DEAD_CYC
) (
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      reset,
    // Requested side
    input  wire hbc_drv_t  req,
    // Gate drive
    output hbc_gate_t      gate
);
    hbc_drv_t                applied_reg;
    logic [`HBC_DEAD_W-1:0]  dead_reg;

    // Off goes at once; a new side waits out the dead time
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            applied_reg <= DRV_OFF;
            dead_reg    <= '0;
        end else if (applied_reg != DRV_OFF && req != applied_reg) begin
            applied_reg <= DRV_OFF;
            dead_reg    <= `HBC_DEAD_W'(DEAD_CYC);
        end else if (dead_reg != '0) begin
            dead_reg    <= dead_reg - 1'b1;
        end else begin
            applied_reg <= req;
        end
    end

    // Decode of the applied flop
    assign gate = '{high_on: applied_reg == DRV_HIGH, low_on: applied_reg == DRV_LOW};
endmodule : hbc_gate

// ---- core/hbc_ctrl.sv ----
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "hbc_defines.svh"
module hbc_ctrl
    import hbc_pkg::*;
#(
    parameter int unsigned SLEEP_CYC = `HBC_SLEEP_CYC,
    parameter int unsigned WAKE_CYC  = `HBC_WAKE_CYC,
    parameter int unsigned RETRY_CYC = `HBC_RETRY_CYC,
    parameter int unsigned OCP_CYC   = `HBC_OCP_CYC,
    parameter int unsigned DEAD_CYC  = `HBC_DEAD_CYC
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Controller pins
    input  wire hbc_pins_t  pins,
    // Analog monitors
    input  wire hbc_sense_t sense,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic [7:0]      reg_rdata,
    // Bridge gates
    output hbc_gate_t       bridge_output_a,
    output hbc_gate_t       bridge_output_b,
    output logic            low_power
);
    typedef enum logic [2:0] {ST_OFF, ST_SLEEP, ST_WAKE, ST_ACTIVE, ST_LINGER} hbc_state_t;

    //--------------------------------------------------
    // Declarations
    //--------------------------------------------------
    hbc_state_t             state_reg;
    hbc_state_t             state_next;
    logic [`HBC_CNT_W-1:0]  tmr_reg;
    logic [`HBC_CNT_W-1:0]  rt_reg;
    logic                   rt_busy_reg;
    logic [`HBC_CNT_W-1:0]  deg_reg [2];
    logic [1:0]             trip;
    logic [1:0]             ocp_dis_reg;
    logic [7:0]             ctrl_reg;
    logic [7:0]             flt_reg;
    logic [7:0]             flt_set;
    logic [7:0]             flt_clr;
    logic                   low_power_reg;
    logic                   split;
    logic                   supply_ok;
    hbc_mode_t              mode_eff;
    logic                   in_a;
    logic                   in_b;
    logic                   idle;
    logic                   bridge_on;
    logic                   retry_done;
    hbc_drv_t               req_a;
    hbc_drv_t               req_b;
    hbc_drv_t               fin_a;
    hbc_drv_t               fin_b;

    //--------------------------------------------------
    // Supply, mode and idle decode
    //--------------------------------------------------
    // Single-supply part has no mode pin, so it is held in PWM
    assign split     = ctrl_reg[`HBC_CTRL_SPLIT];
    assign supply_ok = split ? sense.logic_supply_ok
                             : sense.motor_supply_ok;
    assign mode_eff  = split ? pins.mode : MODE_LOW;
    assign in_a      = pins.direction_or_channel_a_pin;
    assign in_b      = pins.enable_or_channel_b_pin;
    // Floating mode never idles; the controller must drive it low
    assign idle      = (mode_eff == MODE_LOW && !in_a && !in_b)
                    || (mode_eff == MODE_HIGH && !in_b);

    //--------------------------------------------------
    // Power state machine
    //--------------------------------------------------
    // Next state; lockout overrides everything
    always_comb begin
        state_next = state_reg;
        if (!supply_ok) begin
            state_next = ST_OFF;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    state_next = ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (!idle) begin
                        state_next = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    if (idle) begin
                        state_next = ST_SLEEP;
                    end else if (tmr_reg == `HBC_CNT_W'(WAKE_CYC - 1)) begin
                        state_next = ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (idle) begin
                        state_next = ST_LINGER;
                    end
                end
                ST_LINGER: begin
                    if (!idle) begin
                        state_next = ST_ACTIVE;
                    end else if (tmr_reg == `HBC_CNT_W'(SLEEP_CYC - 1)) begin
                        state_next = ST_SLEEP;
                    end
                end
            endcase
        end
    end

    // State flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Shared sleep and wake timer, restarted on each state change
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tmr_reg <= '0;
        end else if (state_next != state_reg) begin
            tmr_reg <= '0;
        end else if (tmr_reg != '1) begin
            tmr_reg <= tmr_reg + 1'b1;
        end
    end

    // Low-power flag comes from a flop
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            low_power_reg <= 1'b1;
        end else begin
            low_power_reg <= state_next == ST_SLEEP || state_next == ST_OFF;
        end
    end
    assign low_power = low_power_reg;

    //--------------------------------------------------
    // Overcurrent deglitch and retry
    //--------------------------------------------------
    // Per-channel deglitch; a short excursion just resets the count
    for (genvar i = 0; i < 2; i++) begin : g_deg
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                deg_reg[i] <= '0;
            end else if (!sense.over_current[i] || state_reg == ST_OFF) begin
                deg_reg[i] <= '0;
            end else if (deg_reg[i] != `HBC_CNT_W'(OCP_CYC - 1)) begin
                deg_reg[i] <= deg_reg[i] + 1'b1;
            end
        end
        assign trip[i] = sense.over_current[i]
                      && deg_reg[i] == `HBC_CNT_W'(OCP_CYC - 1);
    end

    assign retry_done = rt_busy_reg && rt_reg == `HBC_CNT_W'(RETRY_CYC - 1);

    // One retry timer for both halves; a new trip restarts it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rt_reg      <= '0;
            rt_busy_reg <= 1'b0;
        end else if (state_reg == ST_OFF) begin
            rt_reg      <= '0;
            rt_busy_reg <= 1'b0;
        end else if (trip != 2'b00) begin
            rt_reg      <= '0;
            rt_busy_reg <= 1'b1;
        end else if (retry_done) begin
            rt_busy_reg <= 1'b0;
        end else if (rt_busy_reg) begin
            rt_reg      <= rt_reg + 1'b1;
        end
    end

    // Disable flags; a trip in the expiry cycle wins over the release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ocp_dis_reg <= 2'b00;
        end else if (state_reg == ST_OFF) begin
            ocp_dis_reg <= 2'b00;
        end else if (trip != 2'b00) begin
            if (mode_eff == MODE_FLOAT) begin
                ocp_dis_reg <= ocp_dis_reg | trip;
            end else begin
                ocp_dis_reg <= 2'b11;
            end
        end else if (retry_done) begin
            ocp_dis_reg <= 2'b00;
        end
    end

    //--------------------------------------------------
    // Truth tables and output gating
    //--------------------------------------------------
    // Requested side per mode
    always_comb begin
        req_a = DRV_OFF;
        req_b = DRV_OFF;
        unique case (mode_eff)
            MODE_LOW: begin
                req_a = in_a ? DRV_HIGH : (in_b ? DRV_LOW : DRV_OFF);
                req_b = in_b ? (in_a ? DRV_LOW : DRV_HIGH)
                             : (in_a ? DRV_LOW : DRV_OFF);
                if (in_a && in_b) begin
                    req_a = DRV_LOW;
                end
            end
            MODE_HIGH: begin
                req_a = (in_b && in_a) ? DRV_HIGH : DRV_LOW;
                req_b = (in_b && !in_a) ? DRV_HIGH : DRV_LOW;
            end
            MODE_FLOAT: begin
                req_a = in_a ? DRV_HIGH : DRV_LOW;
                req_b = in_b ? DRV_HIGH : DRV_LOW;
            end
        endcase
    end

    // The bridge is live while active or lingering before sleep
    assign bridge_on = supply_ok && !sense.over_temp
                    && (state_reg == ST_ACTIVE || state_reg == ST_LINGER);
    assign fin_a = (bridge_on && !ocp_dis_reg[0]) ? req_a : DRV_OFF;
    assign fin_b = (bridge_on && !ocp_dis_reg[1]) ? req_b : DRV_OFF;

    // Half-bridge gate stages with dead time
    hbc_gate #(.DEAD_CYC(DEAD_CYC)) u_gate_a (
        .clk   (clk),
        .reset (reset),
        .req   (fin_a),
        .gate  (bridge_output_a)
    );
    hbc_gate #(.DEAD_CYC(DEAD_CYC)) u_gate_b (
        .clk   (clk),
        .reset (reset),
        .req   (fin_b),
        .gate  (bridge_output_b)
    );

    //--------------------------------------------------
    // Register port
    //--------------------------------------------------
    // Control register picks the supply variant
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `HBC_CTRL_RST;
        end else if (reg_write && reg_addr == `HBC_REG_CTRL) begin
            ctrl_reg <= reg_wdata;
        end
    end

    // Sticky faults, write one to clear; a new event beats the clear
    always_comb begin
        flt_set = 8'h00;
        flt_set[`HBC_FLT_UNDERVOLTAGE_LOCKOUT]  = state_reg == ST_OFF;
        flt_set[`HBC_FLT_TSD]   = sense.over_temp;
        flt_set[`HBC_FLT_OCP_A] = trip[0];
        flt_set[`HBC_FLT_OCP_B] = trip[1];
        flt_clr = (reg_write && reg_addr == `HBC_REG_FAULT) ? reg_wdata : 8'h00;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flt_reg <= 8'h00;
        end else begin
            flt_reg <= (flt_reg & ~flt_clr) | flt_set;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                `HBC_REG_CTRL:   reg_rdata <= ctrl_reg;
                `HBC_REG_STATUS: reg_rdata <= {state_reg, rt_busy_reg, ocp_dis_reg,
                                               sense.over_temp, !supply_ok};
                `HBC_REG_FAULT:  reg_rdata <= flt_reg;
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    //--------------------------------------------------
    // Assertions
    //--------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_undervoltage_lockout_gates_off: assert property (!supply_ok |=>
        !bridge_output_a.high_on && !bridge_output_a.low_on
        && !bridge_output_b.high_on && !bridge_output_b.low_on)
        else $error("gates on during lockout");

    a_undervoltage_lockout_clears: assert property (state_reg == ST_OFF |=>
        ocp_dis_reg == 2'b00 && !rt_busy_reg)
        else $error("fault logic kept state in lockout");

    a_split_vm_free: assert property (split && sense.logic_supply_ok
        && !sense.motor_supply_ok |=> state_reg != ST_OFF)
        else $error("motor supply caused lockout on split part");

    a_undervoltage_lockout_exit: assert property (state_reg == ST_OFF && supply_ok
        |=> state_reg == ST_SLEEP)
        else $error("lockout not left");

    a_tsd_off: assert property (sense.over_temp |=>
        !bridge_output_a.high_on && !bridge_output_a.low_on
        && !bridge_output_b.high_on && !bridge_output_b.low_on)
        else $error("gates on in over temperature");

    a_ocp_deglitch: assert property ($rose(ocp_dis_reg[0]) |->
        ($past(sense.over_current[0], 1) && $past(sense.over_current[0], 2))
        || ($past(sense.over_current[1], 1) && $past(sense.over_current[1], 2)))
        else $error("overcurrent tripped without deglitch");

    a_retry_hold: assert property ($fell(ocp_dis_reg[0]) && !$past(state_reg == ST_OFF)
        |-> $past(rt_reg) == `HBC_CNT_W'(RETRY_CYC - 1))
        else $error("channel released before full retry");

    a_hb_indep: assert property (mode_eff == MODE_FLOAT && trip == 2'b01
        && !ocp_dis_reg[1] |=> !ocp_dis_reg[1])
        else $error("healthy half-bridge disabled by other fault");

    a_pwm_coast: assert property (state_reg == ST_LINGER && mode_eff == MODE_LOW
        && idle |-> fin_a == DRV_OFF && fin_b == DRV_OFF)
        else $error("outputs driven while idle in pwm");

    a_brake_linger: assert property (state_reg == ST_LINGER && mode_eff == MODE_HIGH
        && idle && bridge_on && ocp_dis_reg == 2'b00 |-> fin_a == DRV_LOW && fin_b == DRV_LOW)
        else $error("no brake before sleep");

    a_sleep_delay: assert property (state_reg == ST_LINGER && state_next == ST_SLEEP
        |-> tmr_reg == `HBC_CNT_W'(SLEEP_CYC - 1))
        else $error("sleep entered early");

    a_wake_time: assert property (state_reg == ST_WAKE ##1 state_reg == ST_ACTIVE
        |-> $past(tmr_reg) == `HBC_CNT_W'(WAKE_CYC - 1))
        else $error("woke before wake time");

    a_leave_idle: assert property (state_reg == ST_LINGER && !idle && supply_ok
        |=> state_reg == ST_ACTIVE)
        else $error("no return to active");

    a_dead_time: assert property ($rose(bridge_output_a.low_on)
        |-> $past(!bridge_output_a.high_on, 1) && $past(!bridge_output_a.high_on, 2))
        else $error("no dead time on half-bridge a");

    c_sleep: cover property (state_reg == ST_LINGER ##1 state_reg == ST_SLEEP);
    c_wake: cover property (state_reg == ST_WAKE ##1 state_reg == ST_ACTIVE);
    c_ocp_both: cover property (ocp_dis_reg == 2'b01 ##[1:50] ocp_dis_reg == 2'b11);
    c_retry: cover property ($fell(ocp_dis_reg[0]));
endmodule : hbc_ctrl

// ---- sim/hbc_mcu_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Controller GPIO model
// ----------------------------------------
module hbc_mcu_model
    import hbc_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Levels asked for by the sequence
    input  wire logic      want_a,
    input  wire logic      want_b,
    input  wire hbc_mode_t want_mode,
    input  wire logic      go_sleep,
    // Pins toward the device
    output hbc_pins_t      pins
);
    // Pulldowns hold the pins low until the controller starts driving
    initial pins = '{1'b0, 1'b0, MODE_LOW};
    // Sleep turns the floating mode pin back into a driven low, all inputs low to save current
    always @(posedge clk) begin
        if (go_sleep) begin
            pins <= '{1'b0, 1'b0, MODE_LOW};
        end else begin
            pins <= '{want_a, want_b, want_mode};
        end
    end
endmodule : hbc_mcu_model

// ---- sim/hbc_ctrl_tb.sv ----
`timescale 1ns/1ps
module hbc_ctrl_tb
    import hbc_pkg::*;
;
    logic       clk, reset, want_a, want_b, go_sleep, reg_write, reg_read, a, b, low_power;
    hbc_mode_t  want_mode, m;
    hbc_pins_t  pins;
    hbc_sense_t sense;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    hbc_gate_t  ga, gb;
    int         errors, check_count;

    hbc_mcu_model mcu (.clk(clk), .want_a(want_a), .want_b(want_b), .want_mode(want_mode),
        .go_sleep(go_sleep), .pins(pins));
    // Short counts keep every delay visible within a few dozen cycles
    hbc_ctrl #(.SLEEP_CYC(20), .WAKE_CYC(10), .RETRY_CYC(30), .OCP_CYC(4), .DEAD_CYC(2)) uut (
        .clk(clk), .reset(reset), .pins(pins), .sense(sense), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .bridge_output_a(ga), .bridge_output_b(gb), .low_power(low_power));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic put(input hbc_mode_t pm, input logic pa, input logic pb);
        @(posedge clk);
        want_mode <= pm;
        want_a    <= pa;
        want_b    <= pb;
    endtask : put
    task automatic gates(input logic [3:0] e);
        chk({4'h0, ga, gb}, {4'h0, e});
    endtask : gates
    // Bounded wait for the sleep flag; running out ends the run
    task automatic await_power(input logic lvl);
        int n;
        n = 0;
        while (low_power !== lvl && n < 60) begin
            cyc(1);
            n++;
        end
        chk({7'h0, low_power}, {7'h0, lvl});
        if (low_power !== lvl) summarize();
    endtask : await_power
    task automatic pulse(input logic [1:0] bits, input int n);
        @(posedge clk);
        sense.over_current <= bits;
        repeat (n) @(posedge clk);
        sense.over_current <= 2'h0;
    endtask : pulse
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        @(posedge clk);
        reg_addr  <= ad;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    // Expected gate pattern {a.high, a.low, b.high, b.low}
    function automatic logic [3:0] expect_gates(input hbc_mode_t fm, input logic fa, input logic fb);
        case (fm)
            MODE_LOW:  return (fa & fb) ? 4'h5 : fa ? 4'h9 : fb ? 4'h6 : 4'h0;
            MODE_HIGH: return !fb ? 4'h5 : fa ? 4'h9 : 4'h6;
            default:   return {fa, !fa, fb, !fb};
        endcase
    endfunction : expect_gates

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        errors = 0;
        check_count = 0;
        reset = 1'b1;
        {want_a, want_b, go_sleep, reg_write, reg_read} = 5'h00;
        want_mode = MODE_LOW;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sense = '{1'b1, 1'b1, 1'b0, 2'h0};
        void'($urandom(10507));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(8'h00, 8'h01);
        rd(8'h0C, 8'h00);
        put(MODE_LOW, 1'b1, 1'b0);
        await_power(1'b0);
        // Wake time plus one gate cycle before the bridge drives
        cyc(12);
        gates(4'h9);
        // Random non-idle pin states across all three schemes, mode changed on the fly
        for (int i = 0; i < 40; i++) begin
            m = hbc_mode_t'($urandom_range(2));
            a = 1'($urandom_range(1));
            b = 1'($urandom_range(1));
            if (m == MODE_LOW && !a && !b) a = 1'b1;
            if (m == MODE_HIGH) b = 1'b1;
            put(m, a, b);
            cyc(8);
            gates(expect_gates(m, a, b));
        end
        $display("done: random modes");
        put(MODE_FLOAT, 1'b1, 1'b1);
        cyc(8);
        pulse(2'h1, 3);
        cyc(4);
        gates(4'hA);
        pulse(2'h1, 6);
        cyc(2);
        gates(4'h2);
        pulse(2'h2, 6);
        cyc(2);
        gates(4'h0);
        cyc(22);
        gates(4'h0);
        cyc(30);
        gates(4'hA);
        $display("done: overcurrent");
        @(posedge clk);
        sense.over_temp <= 1'b1;
        cyc(3);
        gates(4'h0);
        @(posedge clk);
        sense.over_temp <= 1'b0;
        cyc(8);
        gates(4'hA);
        @(posedge clk);
        sense.motor_supply_ok <= 1'b0;
        cyc(4);
        gates(4'hA);
        @(posedge clk);
        sense.logic_supply_ok <= 1'b0;
        cyc(3);
        gates(4'h0);
        chk({7'h0, low_power}, 8'h01);
        @(posedge clk);
        sense <= '{1'b1, 1'b1, 1'b0, 2'h0};
        await_power(1'b0);
        cyc(12);
        gates(4'hA);
        rd(8'h08, 8'h0F);
        wr(8'h08, 8'h05);
        rd(8'h08, 8'h0A);
        $display("done: faults");
        put(MODE_LOW, 1'b0, 1'b0);
        cyc(4);
        gates(4'h0);
        chk({7'h0, low_power}, 8'h00);
        await_power(1'b1);
        put(MODE_HIGH, 1'b1, 1'b1);
        await_power(1'b0);
        cyc(12);
        gates(4'h9);
        put(MODE_HIGH, 1'b1, 1'b0);
        // Side change on A waits out the dead time
        cyc(6);
        gates(4'h5);
        await_power(1'b1);
        cyc(2);
        gates(4'h0);
        put(MODE_FLOAT, 1'b0, 1'b0);
        await_power(1'b0);
        @(posedge clk);
        go_sleep <= 1'b1;
        await_power(1'b1);
        gates(4'h0);
        rd(8'h04, 8'h20);
        $display("done: sleep paths");
        // Single-supply variant: motor supply drives the lockout
        wr(8'h00, 8'h00);
        @(posedge clk);
        sense.motor_supply_ok <= 1'b0;
        cyc(2);
        chk({7'h0, low_power}, 8'h01);
        rd(8'h04, 8'h01);
        $display("done: single supply");
        summarize();
    end
endmodule : hbc_ctrl_tb
